// File: scrs_board.sv
// board model: reset driver, strap pins and the dual reset pin
// assumes the bench moves its controls just after a rising edge
`timescale 1ns/100ps
module scrs_board (
    input wire logic core_clk,
    input wire logic holdReset,
    input wire logic [1:0] ratioSet,
    input wire logic [2:0] bootSet,
    input wire logic pullLow,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    output logic rst_n,
    output logic [1:0] ratioSelPin,
    output logic [2:0] bootModePin,
    output logic resetPinIn
);
    // power-up: reset low before the first edge
    initial begin
        rst_n = 1'b0;
        ratioSelPin = 2'h0;
        bootModePin = 3'h0;
    end
    // straps and reset change on the falling edge only
    always @(negedge core_clk) begin
        ratioSelPin <= ratioSet;
        bootModePin <= bootSet;
        rst_n <= !holdReset;
    end
    // pin: device drive wins, else external pull-down, else the pull-up
    assign resetPinIn = resetPinOe ? resetPinOut : !pullLow;
endmodule

// File: scrs_pkg.sv
// package for the start-up clock and reset sequencer
// assumes one clock, core_clk, and an active-low asynchronous reset
package scrs_pkg;
    // ratio-select pin codes
    localparam logic [1:0] RATIO_CODE_8 = 2'h0;
    localparam logic [1:0] RATIO_CODE_32 = 2'h1;
    localparam logic [1:0] RATIO_CODE_16 = 2'h2;
    localparam logic [1:0] RATIO_CODE_RSVD = 2'h3;
    // multiplier values for each ratio
    localparam logic [5:0] RATIO_MULT_8 = 6'h08;
    localparam logic [5:0] RATIO_MULT_32 = 6'h20;
    localparam logic [5:0] RATIO_MULT_16 = 6'h10;
    // pll lock wait in reference cycles
    localparam int LOCK_WAIT_CYCLES = 4096;
    // divider value after reset
    localparam logic [3:0] RST_DIVIDER = 4'h1;
    // running-reset control bit position
    localparam int RUNRST_EN_BIT = 0;
    // edges the strap synchronisers need to show the pins after release
    localparam logic [1:0] SYNC_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        SEQ_RESET = 2'b00,
        SEQ_LOCK = 2'b01,
        SEQ_RUN = 2'b10
    } scrs_state_e;

    // clock setting carried to the pll
    typedef struct packed {
        logic [5:0] mult;
        logic [3:0] div;
    } scrs_pll_s;

    // decode the ratio pins; reserved falls back to 8:1
    function automatic logic [5:0] ratio_mult(input logic [1:0] code);
        logic [5:0] m;
        m = RATIO_MULT_8;
        if (code == RATIO_CODE_32) begin
            m = RATIO_MULT_32;
        end else if (code == RATIO_CODE_16) begin
            m = RATIO_MULT_16;
        end
        return m;
    endfunction
endpackage

// File: scrs_sequencer.sv
// start-up clock and reset sequencer: straps, pll lock wait, reset pin
// assumes core_clk is the reference clock and rst_n the reset pin
`timescale 1ns/100ps
// How it works
// - ratio pins select 8, 32, 16; 11 reserved
// - software may reprogram pll after reset
// - wait 4096 cycles, then fetch reset vector
// - dual reset pin is output by default
// - control bit 0 makes it running-reset input
// - boot mode taken from three pins
module scrs_sequencer
    import scrs_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_WAIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] ratioSelPin,
    input wire logic [2:0] bootModePin,
    input wire logic runResetCtrlWr,
    input wire logic [7:0] runResetCtrlData,
    input wire logic pllCtrlWr,
    input wire logic [9:0] pllCtrlData,
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe,
    output logic coreRun,
    output logic fetchVector,
    output logic [2:0] bootMode,
    output logic ratioReserved,
    output logic [9:0] pllSetting,
    output logic runResetEnable,
    output logic runResetReq
);
    localparam int CW = $clog2(LOCK_CYCLES + 1);

    logic [1:0] ratioSync; // synchronised ratio pins
    logic [2:0] bootSync; // synchronised boot pins
    logic [0:0] pinSync; // synchronised pin, high while pulled low
    logic [1:0] settle_ff; // edges since release, stops at two
    logic captured_ff; // straps taken once after release
    logic [1:0] ratio_ff; // held ratio code
    logic ratioRsvd_ff; // held ratio code is the reserved one
    logic [2:0] boot_ff; // held boot mode
    scrs_state_e state_ff; // sequencer state
    logic [CW-1:0] lockCnt_ff; // pll lock counter
    scrs_pll_s pll_ff; // pll multiplier and divider
    logic ctrl_ff; // running-reset control bit 0
    logic pinPrev_ff; // pin seen low at the last edge
    logic run_ff; // core running
    logic vec_ff; // reset-vector fetch pulse
    logic rstOut_ff; // reset-out level, active low
    logic oe_ff; // drive enable
    logic req_ff; // running reset pulse

    scrs_sync #(.WIDTH(2)) uRatio (.core_clk(core_clk), .rst_n(rst_n),
        .asyncIn(ratioSelPin), .syncOut(ratioSync));
    scrs_sync #(.WIDTH(3)) uBoot (.core_clk(core_clk), .rst_n(rst_n),
        .asyncIn(bootModePin), .syncOut(bootSync));
    // pin reads high through its pull-up when idle; it is fed inverted so
    // the synchroniser's reset level equals the idle level, no false edge
    scrs_sync #(.WIDTH(1)) uPin (.core_clk(core_clk), .rst_n(rst_n),
        .asyncIn(!resetPinIn), .syncOut(pinSync));

    // settle count: synchroniser outputs hold reset zeros for two edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_ff <= 2'h0;
        end else if (settle_ff != SYNC_SETTLE) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    // strap capture: first clock after the synchronised straps settle
    // board keeps pins steady across reset, so a late sample is safe
    // a strap moved within two cycles of release may be caught either way
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            captured_ff <= 1'b0;
            ratio_ff <= RATIO_CODE_8;
            ratioRsvd_ff <= 1'b0;
            boot_ff <= 3'h0;
        end else if (!captured_ff && settle_ff == SYNC_SETTLE) begin
            captured_ff <= 1'b1;
            ratio_ff <= ratioSync;
            ratioRsvd_ff <= (ratioSync == RATIO_CODE_RSVD);
            boot_ff <= bootSync;
        end
    end

    // sequencer: reset, lock wait, run
    // the counter relies on a free-running reference clock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SEQ_RESET;
            lockCnt_ff <= '0;
        end else begin
            case (state_ff)
                SEQ_RESET: begin
                    state_ff <= SEQ_LOCK;
                    lockCnt_ff <= '0;
                end
                SEQ_LOCK: begin
                    // 4096 cycles counted from leaving reset
                    if (lockCnt_ff == CW'(LOCK_CYCLES - 2)) begin
                        state_ff <= SEQ_RUN;
                    end
                    lockCnt_ff <= lockCnt_ff + 1'b1;
                end
                SEQ_RUN: begin
                    state_ff <= SEQ_RUN;
                end
                default: begin
                    state_ff <= SEQ_RESET;
                end
            endcase
        end
    end

    // core run flag and one-cycle vector fetch strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            vec_ff <= 1'b0;
        end else begin
            run_ff <= (state_ff == SEQ_RUN);
            vec_ff <= (state_ff == SEQ_RUN) && !run_ff;
        end
    end

    // pll setting: strap ratio at start-up, software writes once running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_ff <= '{mult: RATIO_MULT_8, div: RST_DIVIDER};
        end else if (run_ff && pllCtrlWr) begin
            pll_ff <= scrs_pll_s'(pllCtrlData);
        end else if (!run_ff) begin
            pll_ff <= '{mult: ratio_mult(ratio_ff), div: RST_DIVIDER};
        end
    end

    // running-reset control; writes ignored until the core runs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= 1'b0;
        end else if (run_ff && runResetCtrlWr) begin
            ctrl_ff <= runResetCtrlData[RUNRST_EN_BIT];
        end
    end

    // reset pin: drives reset-out, low until the run state, then high; input when enabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstOut_ff <= 1'b0;
            oe_ff <= 1'b1;
            pinPrev_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            rstOut_ff <= (state_ff == SEQ_RUN);
            oe_ff <= !ctrl_ff;
            pinPrev_ff <= pinSync[0];
            // pin newly pulled low in input mode requests a running reset
            req_ff <= ctrl_ff && !pinPrev_ff && pinSync[0];
        end
    end

    // every output comes straight from its flop
    assign resetPinOut = rstOut_ff;
    assign resetPinOe = oe_ff;
    assign coreRun = run_ff;
    assign fetchVector = vec_ff;
    assign bootMode = boot_ff;
    assign ratioReserved = ratioRsvd_ff;
    assign pllSetting = pll_ff;
    assign runResetEnable = ctrl_ff;
    assign runResetReq = req_ff;

    // run begins exactly after the lock wait
    lock_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(run_ff) |-> $past(state_ff == SEQ_LOCK, 2))
        else $error("core ran without lock wait");
    vec_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fetchVector |=> !fetchVector)
        else $error("vector fetch longer than one cycle");
    vec_with_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        fetchVector |-> coreRun && !$past(coreRun))
        else $error("vector fetch not at run start");
    pin_default_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_ff |=> resetPinOe)
        else $error("reset pin not driven by default");
    pin_input_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_ff |=> !resetPinOe)
        else $error("reset pin still driven as input");
    req_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        runResetReq |-> $past(ctrl_ff))
        else $error("running reset while disabled");
    strap_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(captured_ff) |-> $stable(boot_ff) && $stable(ratio_ff))
        else $error("straps changed after capture");
    ratio_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        captured_ff && !run_ff && ratio_ff == RATIO_CODE_32
        |=> pll_ff.mult == RATIO_MULT_32)
        else $error("wrong start-up multiplier");
    pll_write_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        run_ff && pllCtrlWr |=> pllSetting == $past(pllCtrlData))
        else $error("pll write not taken");
    boot_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(captured_ff) |-> bootMode == $past(bootSync))
        else $error("boot mode not from pins");
    // reserved flag must follow the captured pins, not stay at reset zero
    rsvd_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(captured_ff) |-> ratioReserved == ($past(ratioSync) == RATIO_CODE_RSVD))
        else $error("reserved ratio flag wrong");

    run_seen_c: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(coreRun));
    pll_wr_c: cover property (@(posedge core_clk) disable iff (!rst_n) run_ff && pllCtrlWr);
    in_mode_c: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(resetPinOe));
    req_c: cover property (@(posedge core_clk) disable iff (!rst_n) runResetReq);
    rsvd_c: cover property (@(posedge core_clk) disable iff (!rst_n) ratioReserved);
endmodule

// File: scrs_sequencer_bench.sv
// bench for the start-up sequencer: straps, lock wait, pll and reset pin
// assumes the lock count is shortened to 16 cycles
`timescale 1ns/100ps
module scrs_sequencer_bench;
    import scrs_pkg::*;
    localparam int LOCK = 16; // short lock wait keeps the run brief
    logic core_clk, rst_n, holdReset, pullLow, runResetCtrlWr, pllCtrlWr, resetPinIn;
    logic resetPinOut, resetPinOe, coreRun, fetchVector, ratioReserved;
    logic runResetEnable, runResetReq;
    logic [1:0] ratioSet, ratioSelPin;
    logic [2:0] bootSet, bootModePin, bootMode;
    logic [7:0] runResetCtrlData;
    logic [9:0] pllCtrlData, pllSetting;
    logic [5:0] multTab [4] = '{RATIO_MULT_8, RATIO_MULT_32, RATIO_MULT_16, RATIO_MULT_8};
    int mismatches, nChecks;
    scrs_board board_u (.core_clk(core_clk), .holdReset(holdReset), .ratioSet(ratioSet),
        .bootSet(bootSet), .pullLow(pullLow), .resetPinOut(resetPinOut),
        .resetPinOe(resetPinOe), .rst_n(rst_n), .ratioSelPin(ratioSelPin),
        .bootModePin(bootModePin), .resetPinIn(resetPinIn));
    scrs_sequencer #(.LOCK_CYCLES(LOCK)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .ratioSelPin(ratioSelPin), .bootModePin(bootModePin),
        .runResetCtrlWr(runResetCtrlWr), .runResetCtrlData(runResetCtrlData),
        .pllCtrlWr(pllCtrlWr), .pllCtrlData(pllCtrlData), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .coreRun(coreRun),
        .fetchVector(fetchVector), .bootMode(bootMode), .ratioReserved(ratioReserved),
        .pllSetting(pllSetting), .runResetEnable(runResetEnable), .runResetReq(runResetReq));
    // steady reference clock, never stopped
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // verdict and end of run
    task finish_test;
        if (mismatches == 0 && nChecks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // compare one value, four-state exact
    task cmp(input logic [9:0] got, input logic [9:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // straps settle one edge before reset; returns at the release edge
    task do_reset(input logic [1:0] r, input logic [2:0] b);
        @(posedge core_clk);
        ratioSet <= r;
        bootSet <= b;
        @(posedge core_clk);
        holdReset <= 1'b1;
        repeat (5) @(posedge core_clk);
        holdReset <= 1'b0;
        @(negedge core_clk);
    endtask
    // count edges until the core runs; bounded
    task wait_run(output int n);
        n = 0;
        while (coreRun !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= 100) begin
            mismatches++;
            finish_test();
        end
    endtask
    // one write strobe of one cycle
    task wr(input bit isPll, input logic [9:0] d);
        @(negedge core_clk);
        if (isPll) begin
            pllCtrlWr = 1'b1;
            pllCtrlData = d;
        end else begin
            runResetCtrlWr = 1'b1;
            runResetCtrlData = d[7:0];
        end
        @(negedge core_clk);
        pllCtrlWr = 1'b0;
        runResetCtrlWr = 1'b0;
    endtask
    // every ratio code, boot straps, lock wait, then strap changes ignored
    task t_straps;
        int n;
        for (int c = 0; c < 4; c++) begin
            do_reset(c[1:0], 3'(7 - c));
            cmp({7'h0, coreRun, resetPinOe, resetPinOut}, 10'h2);
            wait_run(n);
            cmp(10'(n), 10'(LOCK + 1));
            cmp({9'h0, fetchVector}, 10'h1);
            cmp({7'h0, bootMode}, 10'(7 - c));
            cmp(pllSetting, {multTab[c], RST_DIVIDER});
            cmp({9'h0, ratioReserved}, 10'(c == 3));
            cmp({8'h0, resetPinOe, resetPinOut}, 10'h3);
            ratioSet = ~c[1:0];
            bootSet = c[2:0];
            repeat (5) @(posedge core_clk);
            #1;
            cmp({7'h0, bootMode}, 10'(7 - c));
            cmp({9'h0, ratioReserved}, 10'(c == 3));
            cmp({9'h0, fetchVector}, 10'h0);
        end
    endtask
    // pll write refused during lock, then back-to-back writes while running
    task t_pll;
        int n;
        do_reset(2'h2, 3'h0);
        wr(1'b1, 10'h3ff);
        wait_run(n);
        cmp(pllSetting, {RATIO_MULT_16, RST_DIVIDER});
        @(negedge core_clk);
        pllCtrlWr = 1'b1;
        pllCtrlData = 10'h2a3;
        @(negedge core_clk);
        pllCtrlData = 10'h155;
        cmp(pllSetting, 10'h2a3);
        @(negedge core_clk);
        pllCtrlWr = 1'b0;
        cmp(pllSetting, 10'h155);
    endtask
    // pin turns into running-reset input only by control bit 0
    task t_runrst;
        int n;
        do_reset(2'h0, 3'h0);
        wait_run(n);
        wr(1'b0, 10'h0fe);
        @(negedge core_clk);
        cmp({8'h0, runResetEnable, resetPinOe}, 10'h1);
        wr(1'b0, 10'h001);
        @(negedge core_clk);
        cmp({8'h0, runResetEnable, resetPinOe}, 10'h2);
        pullLow = 1'b1;
        n = 0;
        while (runResetReq !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        cmp(10'(n < 8), 10'h1);
        pullLow = 1'b0;
        wr(1'b0, 10'h000);
        @(negedge core_clk);
        cmp({9'h0, resetPinOe}, 10'h1);
    endtask
    // main sequence
    initial begin
        {holdReset, pullLow, runResetCtrlWr, pllCtrlWr} = 4'h8;
        {ratioSet, bootSet, runResetCtrlData, pllCtrlData} = '0;
        mismatches = 0;
        nChecks = 0;
        repeat (5) @(posedge core_clk);
        t_straps();
        t_pll();
        t_runrst();
        finish_test();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        finish_test();
    end
endmodule

// File: scrs_sync.sv
// two-flop synchroniser, parameterised width
// assumes inputs are asynchronous to core_clk
`timescale 1ns/100ps
module scrs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff; // first stage, read only by second
    logic [WIDTH-1:0] sync_ff; // second stage

    // two stages against metastability
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule
